//--- verilog/mac_pkg.sv
// constants, types and helpers of the multiply-accumulate unit
// Overview of operation
// - major 011100, function 000000 is signed add; 15:13 zero; 12:11 pick acc
// - signed 32x32 product, full 64 bits, added to the chosen accumulator
// - unsigned 32x32 product, 64 bits, added to the chosen accumulator
// - integer forms raise no exception; the accumulator wraps modulo 2^64
// - integer forms write only the chosen accumulator, never a GPR
// - two-bit select picks one of four accumulators; 0 is the base pair
// - upper half: major 011111, function 110000, sub 10100 or 10000 (sat)
// - lower half: same major and function, sub 10110 or 10010 (sat)
// - upper form multiplies bits 31:16 as Q15, shifted left one bit
// - lower form multiplies bits 15:0 as Q15, shifted left one bit
// - both halves 0x8000 give 0x7FFFFFFF and count as saturation
// - plain form adds the sign-extended Q31 value, keeping 64 bits
// - saturating form clamps a non-Q31 sum to Q31 max or min, extended
// - overflow or saturation sets sticky flag bit 16 plus accumulator index
// - fractional forms raise no exception that depends on operands
// - fractional forms raise only reserved or extension-disabled exceptions
package mac_pkg;
	// ========================================
	// instruction encoding
	localparam logic [5:0] OPC_GROUP_B = 6'h1C;
	localparam logic [5:0] OPC_GROUP_C = 6'h1F;
	localparam logic [5:0] FN_SIGNED_ADD = 6'h00;
	localparam logic [5:0] FN_UNSIGNED_ADD = 6'h01;
	localparam logic [5:0] FN_DOT_GROUP = 6'h30;
	localparam logic [4:0] SUB_UPPER = 5'h14;
	localparam logic [4:0] SUB_UPPER_SAT = 5'h10;
	localparam logic [4:0] SUB_LOWER = 5'h16;
	localparam logic [4:0] SUB_LOWER_SAT = 5'h12;
	// ========================================
	// fixed point limits
	localparam logic [15:0] Q15_NEG_ONE = 16'h8000;
	localparam logic [31:0] Q31_MAX = 32'h7FFFFFFF;
	localparam logic [31:0] Q31_MIN = 32'h80000000;
	localparam int NUM_ACC = 4;
	localparam int FLAG_LSB = 16;
	// ========================================
	// register map and reset values
	localparam int ADDR_W = 8;
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_CFG = 8'h04;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h0C;
	localparam logic [7:0] OFS_ACC_BASE = 8'h10;
	localparam logic [7:0] OFS_ACC_LAST = 8'h2C;
	localparam int CFG_ENABLE_BIT = 0;
	localparam logic CFG_ENABLE_RESET = 1'b1;
	localparam int IRQ_RSVD_BIT = 4;
	localparam int IRQ_DIS_BIT = 5;
	localparam int IRQ_W = 6;
	localparam logic [5:0] IRQ_MASK_RESET = 6'h00;
	localparam logic [3:0] FLAGS_RESET = 4'h0;
	// ========================================
	// operation kinds
	typedef enum logic [1:0] {
		MAC_OP_NONE,
		MAC_OP_SMADD,
		MAC_OP_UMADD,
		MAC_OP_FRAC
	} mac_op_type;
	// true when a 64-bit value fits a signed 32-bit Q31 value
	function automatic logic mac_fits_q31(input logic [63:0] v);
		mac_fits_q31 = (v[63:31] == {33{1'b0}}) || (v[63:31] == {33{1'b1}});
	endfunction
	// sign-extend a Q31 word to the accumulator width
	function automatic logic [63:0] mac_sext(input logic [31:0] v);
		mac_sext = {{32{v[31]}}, v};
	endfunction
endpackage

//--- verilog/mac_dec_if.sv
// decoded instruction fields passed between core and decoder
`timescale 1ns/10ps
interface mac_dec_if;
	logic [31:0] instr;
	mac_pkg::mac_op_type op;
	logic [1:0] acc_sel;
	logic upper;
	logic sat;
	logic reserved;
	modport dec (input instr, output op, acc_sel, upper, sat, reserved);
	modport core (output instr, input op, acc_sel, upper, sat, reserved);
endinterface

//--- verilog/mac_decode.sv
// instruction decoder of the multiply-accumulate unit
`timescale 1ns/10ps
module mac_decode (
	// decoded fields
	mac_dec_if.dec d
);
	wire [5:0] opc = d.instr[31:26];
	wire [5:0] fn = d.instr[5:0];
	wire [4:0] sub = d.instr[10:6];
	wire zero_hi = (d.instr[15:13] == 3'h0);
	wire zero_sub = (sub == 5'h00);
	// integer group match
	wire is_b = (opc == mac_pkg::OPC_GROUP_B) &&
		((fn == mac_pkg::FN_SIGNED_ADD) ||
		(fn == mac_pkg::FN_UNSIGNED_ADD));
	// fractional group match
	wire sub_up = (sub == mac_pkg::SUB_UPPER) ||
		(sub == mac_pkg::SUB_UPPER_SAT);
	wire sub_lo = (sub == mac_pkg::SUB_LOWER) ||
		(sub == mac_pkg::SUB_LOWER_SAT);
	wire is_c = (opc == mac_pkg::OPC_GROUP_C) &&
		(fn == mac_pkg::FN_DOT_GROUP) && (sub_up || sub_lo);
	// fields that must be zero make a reserved instruction
	assign d.reserved = (is_b && !(zero_hi && zero_sub)) ||
		(is_c && !zero_hi);
	assign d.op = d.reserved ? mac_pkg::MAC_OP_NONE :
		is_b ? ((fn == mac_pkg::FN_SIGNED_ADD) ? mac_pkg::MAC_OP_SMADD :
		mac_pkg::MAC_OP_UMADD) :
		is_c ? mac_pkg::MAC_OP_FRAC : mac_pkg::MAC_OP_NONE;
	assign d.acc_sel = d.instr[12:11];
	assign d.upper = sub_up;
	assign d.sat = (sub == mac_pkg::SUB_UPPER_SAT) ||
		(sub == mac_pkg::SUB_LOWER_SAT);
endmodule

//--- verilog/mac_acc_file.sv
// four 64-bit accumulators with high and low 32-bit word write enables
`timescale 1ns/10ps
module mac_acc_file #(
	parameter int NUM = 4
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// write port
	input wire logic [1:0] wr_idx,
	input wire logic we_hi,
	input wire logic we_lo,
	input wire logic [63:0] wr_data,
	// read ports
	input wire logic [1:0] rd_idx_a,
	output logic [63:0] rd_data_a,
	input wire logic [1:0] rd_idx_b,
	output logic [63:0] rd_data_b
);
	initial begin
		if (NUM != 4)
			$error("accumulator file serves exactly four entries");
	end
	logic [63:0] mem_q [NUM];
	// storage; index 0 doubles as the base high/low pair
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < NUM; i++)
				mem_q[i] <= 64'h0;
		end else begin
			if (we_hi)
				mem_q[wr_idx][63:32] <= wr_data[63:32];
			if (we_lo)
				mem_q[wr_idx][31:0] <= wr_data[31:0];
		end
	end
	assign rd_data_a = mem_q[rd_idx_a];
	assign rd_data_b = mem_q[rd_idx_b];
endmodule

//--- verilog/mac_unit.sv
// multiply-accumulate unit top with register port and interrupt
`timescale 1ns/10ps
module mac_unit (
	// clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// instruction issue from the pipeline
	input wire logic issue_valid,
	input wire logic [31:0] issue_instr,
	input wire logic [31:0] source_operand_a,
	input wire logic [31:0] source_operand_b,
	// completion and exceptions
	output logic op_done,
	output logic exc_reserved,
	output logic exc_disabled,
	output logic gpr_write_en,
	// register port
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// interrupt
	output logic irq
);
	// ========================================
	// decode
	mac_dec_if dec_if ();
	assign dec_if.instr = issue_instr;
	mac_decode u_dec (
		.d(dec_if.dec)
	);
	wire mac_pkg::mac_op_type op = dec_if.op;
	wire [1:0] acc_sel = dec_if.acc_sel;

	// ========================================
	// state registers
	logic [3:0] flags_q;
	logic [3:0] flags_d;
	logic cfg_en_q;
	logic cfg_en_d;
	logic [5:0] stat_q;
	logic [5:0] stat_d;
	logic [5:0] mask_q;
	logic [5:0] mask_d;
	logic [31:0] rdata_q;
	logic [31:0] rdata_d;
	logic done_q;
	logic rsvd_q;
	logic dis_q;

	// ========================================
	// accumulator storage
	logic [63:0] acc_cur;
	logic [63:0] acc_bus;
	logic [63:0] acc_wdata;
	logic [1:0] acc_widx;
	logic acc_we_hi;
	logic acc_we_lo;
	wire [7:0] acc_rel = reg_addr - mac_pkg::OFS_ACC_BASE;
	wire [1:0] bus_idx = acc_rel[4:3];
	wire bus_hi = reg_addr[2];
	mac_acc_file #(
		.NUM(mac_pkg::NUM_ACC)
	) u_acc (
		.mclk(mclk),
		.rst_n(rst_n),
		.wr_idx(acc_widx),
		.we_hi(acc_we_hi),
		.we_lo(acc_we_lo),
		.wr_data(acc_wdata),
		.rd_idx_a(acc_sel),
		.rd_data_a(acc_cur),
		.rd_idx_b(bus_idx),
		.rd_data_b(acc_bus)
	);

	// ========================================
	// integer multiply, one multiplier serves both signednesses
	wire is_signed = (op == mac_pkg::MAC_OP_SMADD);
	wire ext_a = is_signed & source_operand_a[31];
	wire ext_b = is_signed & source_operand_b[31];
	wire signed [65:0] wide_prod = $signed({ext_a, source_operand_a}) *
		$signed({ext_b, source_operand_b});
	wire [63:0] int_prod = wide_prod[63:0];
	wire [63:0] int_sum = acc_cur + int_prod; // wraps

	// ========================================
	// fractional halfword multiply
	wire upper = dec_if.upper;
	wire sat = dec_if.sat;
	wire [15:0] half_a = upper ? source_operand_a[31:16] :
		source_operand_a[15:0];
	wire [15:0] half_b = upper ? source_operand_b[31:16] :
		source_operand_b[15:0];
	wire signed [31:0] half_prod = $signed(half_a) * $signed(half_b);
	wire both_neg = (half_a == mac_pkg::Q15_NEG_ONE) &&
		(half_b == mac_pkg::Q15_NEG_ONE);
	wire [31:0] q31_val = both_neg ? mac_pkg::Q31_MAX :
		{half_prod[30:0], 1'b0};
	wire [63:0] q31_ext = mac_pkg::mac_sext(q31_val);
	wire [63:0] frac_sum = acc_cur + q31_ext;
	// signed 64-bit overflow of the plain accumulation
	wire ovf64 = (acc_cur[63] == q31_ext[63]) && (frac_sum[63] != acc_cur[63]);
	wire true_neg = ovf64 ? acc_cur[63] : frac_sum[63];
	wire fits = mac_pkg::mac_fits_q31(frac_sum) && !ovf64;
	wire [63:0] clamp_val = true_neg ? mac_pkg::mac_sext(mac_pkg::Q31_MIN) :
		mac_pkg::mac_sext(mac_pkg::Q31_MAX);
	wire [63:0] frac_res = (sat && !fits) ? clamp_val : frac_sum;
	wire frac_event = both_neg || (sat ? !fits : ovf64);

	// ========================================
	// issue control: what runs, what traps
	wire int_go = issue_valid && ((op == mac_pkg::MAC_OP_SMADD) ||
		(op == mac_pkg::MAC_OP_UMADD));
	wire frac_ok = issue_valid && (op == mac_pkg::MAC_OP_FRAC);
	wire frac_go = frac_ok && cfg_en_q; // no operand-dependent trap
	wire dis_evt = frac_ok && !cfg_en_q;
	wire rsvd_evt = issue_valid && dec_if.reserved;
	wire inst_we = int_go || frac_go;
	wire [3:0] flag_set = (frac_go && frac_event) ?
		(4'h1 << acc_sel) : 4'h0;

	// ========================================
	// register port decode
	wire hit_ctrl = (reg_addr == mac_pkg::OFS_CTRL);
	wire hit_cfg = (reg_addr == mac_pkg::OFS_CFG);
	wire hit_stat = (reg_addr == mac_pkg::OFS_IRQ_STAT);
	wire hit_mask = (reg_addr == mac_pkg::OFS_IRQ_MASK);
	wire hit_acc = (reg_addr >= mac_pkg::OFS_ACC_BASE) &&
		(reg_addr <= mac_pkg::OFS_ACC_LAST) && (reg_addr[1:0] == 2'h0);
	wire ctrl_wr = reg_wr && hit_ctrl;
	wire bus_acc_wr = reg_wr && hit_acc && !inst_we;

	// ========================================
	// accumulator write selection; an instruction beats a bus write
	assign acc_widx = inst_we ? acc_sel : bus_idx;
	assign acc_wdata = inst_we ?
		((op == mac_pkg::MAC_OP_FRAC) ? frac_res : int_sum) :
		{reg_wdata, reg_wdata};
	assign acc_we_hi = inst_we || (bus_acc_wr && bus_hi);
	assign acc_we_lo = inst_we || (bus_acc_wr && !bus_hi);

	// ========================================
	// next values; hardware set wins over software clear
	assign flags_d = (ctrl_wr ? reg_wdata[19:16] : flags_q) |
		flag_set;
	assign cfg_en_d = (reg_wr && hit_cfg) ?
		reg_wdata[mac_pkg::CFG_ENABLE_BIT] : cfg_en_q;
	wire [5:0] stat_set = {dis_evt, rsvd_evt, flag_set};
	wire [5:0] stat_clr = (reg_wr && hit_stat) ? reg_wdata[5:0] : 6'h00;
	assign stat_d = (stat_q & ~stat_clr) | stat_set;
	assign mask_d = (reg_wr && hit_mask) ? reg_wdata[5:0] : mask_q;
	wire [31:0] acc_word = bus_hi ? acc_bus[63:32] : acc_bus[31:0];
	assign rdata_d = !reg_rd ? 32'h00000000 :
		hit_ctrl ? {12'h000, flags_q, 16'h0000} :
		hit_cfg ? {31'h00000000, cfg_en_q} :
		hit_stat ? {26'h0000000, stat_q} :
		hit_mask ? {26'h0000000, mask_q} :
		hit_acc ? acc_word : 32'h00000000;

	// control and status registers
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			flags_q <= mac_pkg::FLAGS_RESET;
			cfg_en_q <= mac_pkg::CFG_ENABLE_RESET;
			stat_q <= 6'h00;
			mask_q <= mac_pkg::IRQ_MASK_RESET;
			rdata_q <= 32'h00000000;
		end else begin
			flags_q <= flags_d;
			cfg_en_q <= cfg_en_d;
			stat_q <= stat_d;
			mask_q <= mask_d;
			rdata_q <= rdata_d;
		end
	end

	// completion and exception pulses, one cycle after issue
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			done_q <= 1'b0;
			rsvd_q <= 1'b0;
			dis_q <= 1'b0;
		end else begin
			done_q <= inst_we;
			rsvd_q <= rsvd_evt;
			dis_q <= dis_evt;
		end
	end

	// outputs; no operation here ever writes a GPR
	assign op_done = done_q;
	assign exc_reserved = rsvd_q;
	assign exc_disabled = dis_q;
	assign gpr_write_en = 1'b0;
	assign reg_rdata = rdata_q;
	assign irq = |(stat_q & mask_q);

	// ========================================
	// checks
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_n);

	logic signed [63:0] chk_sprod;
	logic [63:0] chk_uprod;
	logic signed [31:0] chk_hprod;
	assign chk_sprod = $signed(source_operand_a) * $signed(source_operand_b);
	assign chk_uprod = {32'h00000000, source_operand_a} *
		{32'h00000000, source_operand_b};
	assign chk_hprod = $signed(source_operand_a[15:0]) *
		$signed(source_operand_b[15:0]);

	decode_group_b_a: assert property (
		(issue_instr[31:26] == 6'h1C) && (issue_instr[5:0] == 6'h00) &&
		(issue_instr[15:13] == 3'h0) && (issue_instr[10:6] == 5'h00) |->
		op == mac_pkg::MAC_OP_SMADD)
		else $error("signed multiply-add not decoded");
	smadd_math_a: assert property (
		issue_valid && (op == mac_pkg::MAC_OP_SMADD) |->
		acc_wdata == acc_cur + chk_sprod)
		else $error("signed multiply-add sum wrong");
	umadd_math_a: assert property (
		issue_valid && (op == mac_pkg::MAC_OP_UMADD) |->
		acc_wdata == acc_cur + chk_uprod)
		else $error("unsigned multiply-add sum wrong");
	int_no_trap_a: assert property (
		int_go |=> op_done && !exc_reserved && !exc_disabled)
		else $error("integer multiply-add raised an exception");
	acc_target_a: assert property (
		inst_we |-> acc_we_hi && acc_we_lo && acc_widx == acc_sel &&
		!gpr_write_en)
		else $error("instruction wrote the wrong destination");
	lower_frac_a: assert property (
		frac_go && !upper && !both_neg |->
		q31_val == {chk_hprod[30:0], 1'b0})
		else $error("lower halfword product wrong");
	q15_corner_a: assert property (
		frac_go && both_neg |-> q31_val == 32'h7FFFFFFF
		##1 flags_q[$past(acc_sel)])
		else $error("q15 corner not saturated and flagged");
	sat_clamp_a: assert property (
		frac_go && sat |-> mac_pkg::mac_fits_q31(acc_wdata))
		else $error("saturating form left a non-q31 value");
	flag_sticky_a: assert property (
		!ctrl_wr |=> (flags_q & $past(flags_q)) == $past(flags_q))
		else $error("overflow flag dropped without a write");
	frac_no_trap_a: assert property (
		frac_go |=> op_done && !exc_reserved && !exc_disabled)
		else $error("fractional op raised a data exception");
	disabled_trap_a: assert property (
		dis_evt |-> !inst_we ##1 exc_disabled && !op_done)
		else $error("disabled extension not trapped");

	smadd_cov_c: cover property (int_go && is_signed ##1 op_done);
	sat_cov_c: cover property (frac_go && sat && !fits);
	corner_cov_c: cover property (frac_go && both_neg ##1 irq);
endmodule

//--- testbench/mac_core_model.sv
// pipeline-side issue model that feeds instructions to the unit
`timescale 1ns/10ps
module mac_core_model (
	// clock
	input wire logic mclk,
	// instruction issue
	output logic issue_valid,
	output logic [31:0] issue_instr,
	output logic [31:0] source_operand_a,
	output logic [31:0] source_operand_b
);
	// quiet issue port from time zero
	initial begin
		issue_valid = 1'b0;
		issue_instr = 32'h00000000;
		source_operand_a = 32'h00000000;
		source_operand_b = 32'h00000000;
	end
	// one instruction taken at the edge where valid is high
	task automatic issue(input logic [31:0] ins, input logic [31:0] a,
		input logic [31:0] b);
		@(posedge mclk);
		issue_valid <= 1'b1;
		issue_instr <= ins;
		source_operand_a <= a;
		source_operand_b <= b;
		@(posedge mclk);
		issue_valid <= 1'b0;
		// released fields flip so stale values never look valid
		issue_instr <= ~ins;
		source_operand_a <= ~a;
		source_operand_b <= ~b;
	endtask
endmodule

//--- testbench/testbench.sv
// self-checking bench of the multiply-accumulate unit
`timescale 1ns/10ps
`define CHK(n, e, g) chk(n, 64'(e), 64'(g))
module testbench;
	logic mclk, rst_n, issue_valid, op_done, exc_reserved, exc_disabled;
	logic gpr_write_en, reg_wr, reg_rd, irq;
	logic [31:0] issue_instr, source_operand_a, source_operand_b;
	logic [7:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata;
	int n_fail = 0;
	int check_count = 0;
	int cyc = 0;
	// pipeline model and unit under test
	mac_core_model core (.mclk(mclk), .issue_valid(issue_valid),
		.issue_instr(issue_instr), .source_operand_a(source_operand_a),
		.source_operand_b(source_operand_b));
	mac_unit dut (.mclk(mclk), .rst_n(rst_n), .issue_valid(issue_valid),
		.issue_instr(issue_instr), .source_operand_a(source_operand_a),
		.source_operand_b(source_operand_b), .op_done(op_done),
		.exc_reserved(exc_reserved), .exc_disabled(exc_disabled),
		.gpr_write_en(gpr_write_en), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .irq(irq));
	// 40 MHz clock
	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end
	// ========================================
	// helpers
	task automatic chk(input string nm, input logic [63:0] e,
		input logic [63:0] g);
		check_count++;
		if (g !== e) begin
			n_fail++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask
	// read data stands only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
	endtask
	task automatic rchk(input string nm, input logic [7:0] a,
		input logic [31:0] e);
		logic [31:0] d;
		rd(a, d);
		`CHK(nm, e, d);
	endtask
	task automatic set_acc(input int n, input logic [63:0] v);
		wr(mac_pkg::OFS_ACC_BASE + 8'(8 * n), v[31:0]);
		wr(mac_pkg::OFS_ACC_BASE + 8'(8 * n + 4), v[63:32]);
	endtask
	task automatic acc_chk(input int n, input logic [63:0] e);
		logic [31:0] lo, hi;
		rd(mac_pkg::OFS_ACC_BASE + 8'(8 * n), lo);
		rd(mac_pkg::OFS_ACC_BASE + 8'(8 * n + 4), hi);
		`CHK("accumulator", e, {hi, lo});
	endtask
	// issue one op and judge the pulses in the following cycle
	task automatic run(input logic [31:0] ins, input logic [31:0] a,
		input logic [31:0] b, input logic [2:0] e);
		core.issue(ins, a, b);
		#1;
		`CHK("response", e, {op_done, exc_reserved, exc_disabled});
		`CHK("gpr write", 1'b0, gpr_write_en);
	endtask
	function automatic logic [31:0] enc_int(input logic [5:0] fn,
		input logic [1:0] ac);
		return {mac_pkg::OPC_GROUP_B, 10'h022, 3'h0, ac, 5'h00, fn};
	endfunction
	function automatic logic [31:0] enc_frac(input logic [4:0] sub,
		input logic [1:0] ac);
		return {mac_pkg::OPC_GROUP_C, 10'h022, 3'h0, ac, sub,
			mac_pkg::FN_DOT_GROUP};
	endfunction
	// ========================================
	// scenarios
	task automatic t_reset();
		rchk("config", mac_pkg::OFS_CFG, 32'h00000001);
		rchk("control", mac_pkg::OFS_CTRL, 32'h00000000);
		rchk("mask", mac_pkg::OFS_IRQ_MASK, 32'h00000000);
		rchk("unmapped", 8'h40, 32'h00000000);
		$display("test reset done");
	endtask
	task automatic t_integer();
		set_acc(1, 64'h0000000000000010);
		set_acc(3, 64'hFFFFFFFFFFFFFFFF);
		run(enc_int(mac_pkg::FN_SIGNED_ADD, 2'h1), 32'hFFFFFFFE,
			32'h00000003, 3'h4);
		run(enc_int(mac_pkg::FN_UNSIGNED_ADD, 2'h2), 32'hFFFFFFFE,
			32'h00000003, 3'h4);
		run(enc_int(mac_pkg::FN_UNSIGNED_ADD, 2'h3), 32'h00000001,
			32'h00000001, 3'h4);
		acc_chk(1, 64'h000000000000000A);
		acc_chk(2, 64'h00000002FFFFFFFA);
		acc_chk(3, 64'h0000000000000000);
		acc_chk(0, 64'h0000000000000000);
		rchk("control", mac_pkg::OFS_CTRL, 32'h00000000);
		$display("test integer done");
	endtask
	task automatic t_frac();
		logic [4:0] sub [4] = '{mac_pkg::SUB_UPPER, mac_pkg::SUB_LOWER,
			mac_pkg::SUB_UPPER_SAT, mac_pkg::SUB_LOWER_SAT};
		logic [63:0] pre [4] = '{64'h0, 64'h5, 64'h7FFFFFFF,
			64'hFFFFFFFF80000000};
		logic [31:0] oa [4] = '{32'h40001234, 32'h12348000, 32'h40000000,
			32'h00008000};
		logic [31:0] ob [4] = '{32'h40001234, 32'h12348000, 32'h40000000,
			32'h00004000};
		logic [63:0] res [4] = '{64'h20000000, 64'h80000004, 64'h7FFFFFFF,
			64'hFFFFFFFF80000000};
		for (int i = 0; i < 4; i++) begin
			set_acc(i, pre[i]);
		end
		wr(mac_pkg::OFS_IRQ_MASK, 32'h00000002);
		for (int i = 0; i < 4; i++) begin
			run(enc_frac(sub[i], 2'(i)), oa[i], ob[i], 3'h4);
			acc_chk(i, res[i]);
		end
		rchk("control", mac_pkg::OFS_CTRL, 32'h000E0000);
		rchk("status", mac_pkg::OFS_IRQ_STAT, 32'h0000000E);
		`CHK("irq", 1'b1, irq);
		wr(mac_pkg::OFS_IRQ_STAT, 32'h00000002);
		rchk("status", mac_pkg::OFS_IRQ_STAT, 32'h0000000C);
		`CHK("irq", 1'b0, irq);
		wr(mac_pkg::OFS_IRQ_STAT, 32'h0000000C);
		$display("test fractional done");
	endtask
	task automatic t_refuse();
		run(enc_int(mac_pkg::FN_SIGNED_ADD, 2'h1) | 32'h00002000,
			32'h00000001, 32'h00000001, 3'h2);
		acc_chk(1, 64'h0000000080000004);
		wr(mac_pkg::OFS_CFG, 32'h00000000);
		run(enc_frac(mac_pkg::SUB_UPPER, 2'h0), 32'h40000000,
			32'h40000000, 3'h1);
		acc_chk(0, 64'h0000000020000000);
		rchk("status", mac_pkg::OFS_IRQ_STAT, 32'h00000030);
		wr(mac_pkg::OFS_CFG, 32'h00000001);
		run(32'h00000000, 32'h00000001, 32'h00000001, 3'h0);
		$display("test refusal done");
	endtask
	// ========================================
	// verdict and hang guard
	task automatic close_out();
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			n_fail++;
			close_out();
		end
	end
	// main sequence
	initial begin
		rst_n = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 32'h00000000;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		repeat (10) @(posedge mclk);
		rst_n <= 1'b1;
		t_reset();
		t_integer();
		t_frac();
		t_refuse();
		close_out();
	end
endmodule
